// >>> adc_out_pkg.sv
package adc_out_pkg;

   // ---------------------------------------------------------------
   // Sample word layout
   // ---------------------------------------------------------------
   localparam int CODE_W = 14;
   localparam int WORD_W = CODE_W + 2;
   localparam int POS_BIT = CODE_W;
   localparam int NEG_BIT = CODE_W + 1;
   localparam int DDR_PAIRS = CODE_W / 2;

   // ---------------------------------------------------------------
   // Pipeline latency in sampling clock cycles
   // ---------------------------------------------------------------
   localparam int LAT_STD = 14;
   localparam int LAT_SLOW_CMOS = 13;

   // ---------------------------------------------------------------
   // Clamp codes and format conversion
   // ---------------------------------------------------------------
   localparam logic [CODE_W-1:0] CODE_POS_FULL = 14'h3fff;
   localparam logic [CODE_W-1:0] CODE_NEG_FULL = 14'h0000;
   localparam logic [CODE_W-1:0] CODE_MSB_FLIP = 14'h2000;

   // ---------------------------------------------------------------
   // Buffering and synchroniser
   // ---------------------------------------------------------------
   localparam int FIFO_DEPTH = 8;
   localparam int SYNC_W = 6;

   // ---------------------------------------------------------------
   // Modes
   // ---------------------------------------------------------------
   typedef enum logic {FMT_OFFSET_BIN, FMT_TWOS_COMP} fmt_t;
   typedef enum logic {INTF_DDR_LVDS, INTF_CMOS} intf_t;

endpackage

// >>> sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_wr_data,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   output logic [WIDTH-1:0] o_rd_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready
);

   localparam int PTR_W = $clog2(DEPTH);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   // Pointers wrap by overflow, so the depth must be a power of two.
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
      $error("sample_fifo needs a power-of-two depth of at least 2");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PTR_W-1:0] wr_ptr_r;
   logic [PTR_W-1:0] rd_ptr_r;
   logic [PTR_W:0] count_r;
   wire logic do_wr;
   wire logic do_rd;

   // Full and empty come straight from the occupancy count.
   // The count is one bit wider than a pointer, so the full mark fits it.
   assign o_wr_ready = (count_r != (PTR_W+1)'(DEPTH));
   assign o_rd_valid = (count_r != '0);
   assign o_rd_data = mem_r[rd_ptr_r];
   assign do_wr = i_wr_valid & o_wr_ready;
   assign do_rd = o_rd_valid & i_rd_ready;

   // Storage array has no reset; only the pointers and the count need one.
   always_ff @(posedge i_clk) begin
      if (do_wr) begin
         mem_r[wr_ptr_r] <= i_wr_data;
      end
   end

   // Pointer and count update.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_wr) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (do_rd) rd_ptr_r <= rd_ptr_r + 1'b1;
         if (do_wr && !do_rd) count_r <= count_r + 1'b1;
         else if (do_rd && !do_wr) count_r <= count_r - 1'b1;
      end
   end

endmodule

`default_nettype wire

// >>> adc_output_stage.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - While the input is overdriven the overrange flag is high and the code sits at full scale.
// - Positive overdrive gives 0x3fff in offset binary and 0x1fff in two's complement.
// - Negative overdrive gives 0x0000 in offset binary and 0x2000 in two's complement.
// - Flag and clamped code appear fourteen sampling cycles late, thirteen in CMOS mode below 80 MSPS, aligned with their sample.
// - In DDR LVDS mode every sample is presented fourteen sampling cycles after capture.
// - In CMOS mode latency is fourteen cycles above 80 MSPS and thirteen below.
// - The forwarded clock is the inverted sampling clock, so its high time is the input's low time at every rate.
// - In DDR LVDS mode even bits launch on the clock's falling edge and odd bits on its rising.
// - Two output formats exist, chosen by the format pin or by the serial format bit.
// - In CMOS mode each bit has its own pin and is valid at the output clock's rising edge.
module adc_output_stage
   import adc_out_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sample_clk,
   input wire logic i_format_select_pin,
   input wire logic i_data_format_bit,
   input wire logic i_use_serial_cfg,
   input wire logic i_output_interface_bit,
   input wire logic i_rate_below_80,
   input wire logic [CODE_W-1:0] i_smp_code,
   input wire logic i_smp_over_pos,
   input wire logic i_smp_over_neg,
   input wire logic i_smp_valid,
   output logic o_smp_ready,
   output logic [CODE_W-1:0] o_data,
   output logic o_data_valid,
   output logic o_overrange_flag,
   output logic [DDR_PAIRS-1:0] o_ddr_pair,
   output logic o_forwarded_clock_pos,
   output logic o_forwarded_clock_cmos
);

   // ---------------------------------------------------------------
   // Pin synchroniser and sampling clock edge detection
   // ---------------------------------------------------------------
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic sclk_d_r;
   wire logic [SYNC_W-1:0] pins_in;
   wire logic sclk_s;
   wire logic sclk_rise;
   wire logic sclk_fall;

   assign pins_in = {i_sample_clk, i_format_select_pin, i_data_format_bit,
                     i_use_serial_cfg, i_output_interface_bit, i_rate_below_80};
   assign sclk_s = sync2_r[5];
   assign sclk_rise = sclk_s & ~sclk_d_r;
   assign sclk_fall = ~sclk_s & sclk_d_r;

   // Only the second stage reads the first stage; the edge register reads the second.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sclk_d_r <= 1'b0;
      end else begin
         sync1_r <= pins_in;
         sync2_r <= sync1_r;
         sclk_d_r <= sclk_s;
      end
   end

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   wire fmt_t fmt;
   wire intf_t intf;
   wire logic slow_cmos;

   // Serial bit overrides the strap pin when serial configuration is on.
   assign fmt = fmt_t'(sync2_r[2] ? sync2_r[3] : sync2_r[4]);
   assign intf = intf_t'(sync2_r[1]);
   assign slow_cmos = (intf == INTF_CMOS) & sync2_r[0];

   // ---------------------------------------------------------------
   // Input buffer
   // ---------------------------------------------------------------
   wire logic [WORD_W-1:0] fifo_out;
   wire logic fifo_valid;

   // The pipeline drains one word per sampling edge; a full buffer
   // stalls the source through o_smp_ready.
   sample_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_wr_data({i_smp_over_neg, i_smp_over_pos, i_smp_code}),
      .i_wr_valid(i_smp_valid),
      .o_wr_ready(o_smp_ready),
      .o_rd_data(fifo_out),
      .o_rd_valid(fifo_valid),
      .i_rd_ready(sclk_rise)
   );

   // ---------------------------------------------------------------
   // Latency pipeline, one stage per sampling rising edge
   // ---------------------------------------------------------------
   // Each stage holds {valid, neg, pos, code}. An empty buffer at a
   // sampling edge inserts a bubble, marked invalid, so timing holds.
   logic [WORD_W:0] pipe_r [1:LAT_STD];
   wire logic [WORD_W:0] tap;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pipe_r[1] <= '0;
      end else if (sclk_rise) begin
         pipe_r[1] <= fifo_valid ? {1'b1, fifo_out} : '0;
      end
   end

   for (genvar i = 2; i <= LAT_STD; i++) begin : g_pipe
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            pipe_r[i] <= '0;
         end else if (sclk_rise) begin
            pipe_r[i] <= pipe_r[i-1];
         end
      end
   end

   // The output register adds the last stage, so stage 13 or 14 here
   // lands on the pins exactly 13 or 14 edges after capture.
   assign tap = slow_cmos ? pipe_r[LAT_SLOW_CMOS] : pipe_r[LAT_STD];

   // ---------------------------------------------------------------
   // Clamp and format conversion
   // ---------------------------------------------------------------
   wire logic tap_pos;
   wire logic tap_neg;
   wire logic [CODE_W-1:0] clamped;
   wire logic [CODE_W-1:0] out_code;
   wire logic tap_ovr;

   assign tap_pos = tap[POS_BIT];
   assign tap_neg = tap[NEG_BIT];
   // Positive overdrive wins if the front end ever flags both.
   assign clamped = tap_pos ? CODE_POS_FULL :
                    tap_neg ? CODE_NEG_FULL :
                    tap[CODE_W-1:0];
   assign out_code = (fmt == FMT_TWOS_COMP) ? (clamped ^ CODE_MSB_FLIP) : clamped;
   assign tap_ovr = tap[WORD_W] & (tap_pos | tap_neg);

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   wire logic [DDR_PAIRS-1:0] even_bits;
   wire logic [DDR_PAIRS-1:0] odd_bits;

   for (genvar k = 0; k < DDR_PAIRS; k++) begin : g_pairs
      assign even_bits[k] = out_code[2*k];
      assign odd_bits[k] = o_data[2*k+1];
   end

   // Word, flag and valid all move together on the sampling edge.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_data <= '0;
         o_data_valid <= 1'b0;
         o_overrange_flag <= 1'b0;
      end else if (sclk_rise) begin
         o_data <= out_code;
         o_data_valid <= tap[WORD_W];
         o_overrange_flag <= tap_ovr;
      end
   end

   // Sampling rise is the forwarded clock's fall: even bits of the new
   // word; sampling fall is its rise: odd bits of the held word.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ddr_pair <= '0;
      end else if (sclk_rise) begin
         o_ddr_pair <= even_bits;
      end else if (sclk_fall) begin
         o_ddr_pair <= odd_bits;
      end
   end

   // ---------------------------------------------------------------
   // Forwarded clocks
   // ---------------------------------------------------------------
   // The forwarded clock is the inverted sampling clock, so its duty
   // cycle is whatever the input gives; it is not restored below
   // 80 MSPS. Inverting puts its rising edge mid-word for CMOS capture.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_forwarded_clock_pos <= 1'b0;
         o_forwarded_clock_cmos <= 1'b0;
      end else begin
         o_forwarded_clock_pos <= (intf == INTF_DDR_LVDS) & ~sclk_s;
         o_forwarded_clock_cmos <= (intf == INTF_CMOS) & ~sclk_s;
      end
   end

endmodule

`default_nettype wire

// >>> adc_output_stage_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adc_out_checker
   import adc_out_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_format_select_pin,
   input wire logic i_data_format_bit,
   input wire logic i_use_serial_cfg,
   input wire logic [CODE_W-1:0] o_data,
   input wire logic o_data_valid,
   input wire logic o_overrange_flag,
   input wire logic [DDR_PAIRS-1:0] o_ddr_pair,
   input wire logic o_forwarded_clock_pos,
   input wire logic o_forwarded_clock_cmos
);
   // ---------------------------------------------------------------
   // Output stage checks
   // ---------------------------------------------------------------
   // Config only moves under reset, so no settling window is kept.
   wire logic fmt_tc = i_use_serial_cfg ? i_data_format_bit : i_format_select_pin;
   wire logic fwd = o_forwarded_clock_pos | o_forwarded_clock_cmos;
   logic [DDR_PAIRS-1:0] even_w;
   logic [DDR_PAIRS-1:0] odd_w;
   // Halves of the code as they should appear on the two clock phases.
   always_comb begin
      for (int k = 0; k < DDR_PAIRS; k++) begin
         even_w[k] = o_data[2*k];
         odd_w[k] = o_data[2*k+1];
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Clamp codes, flag qualification, launch alignment and clock shape.
   property p_clamp_ob; o_overrange_flag && !fmt_tc |-> o_data inside {14'h3fff, 14'h0000};
   endproperty
   a_clamp_ob: assert property (p_clamp_ob) else $error("Offset clamp code wrong.");
   property p_clamp_tc; o_overrange_flag && fmt_tc |-> o_data inside {14'h1fff, 14'h2000};
   endproperty
   a_clamp_tc: assert property (p_clamp_tc) else $error("Twos clamp code wrong.");
   property p_flag_real; o_overrange_flag |-> o_data_valid; endproperty
   a_flag_real: assert property (p_flag_real) else $error("Flag on a bubble.");
   property p_align; $changed(o_data) || $changed(o_overrange_flag) |-> $fell(fwd); endproperty
   a_align: assert property (p_align) else $error("Output moved off launch edge.");
   property p_ddr_odd; $rose(o_forwarded_clock_pos) |-> o_ddr_pair == odd_w; endproperty
   a_ddr_odd: assert property (p_ddr_odd) else $error("Odd bits wrong.");
   property p_ddr_even; $fell(o_forwarded_clock_pos) |-> o_ddr_pair == even_w; endproperty
   a_ddr_even: assert property (p_ddr_even) else $error("Even bits wrong.");
   property p_cmos_stable; $rose(o_forwarded_clock_cmos) |-> $stable(o_data); endproperty
   a_cmos_stable: assert property (p_cmos_stable) else $error("Data moved at edge.");
   property p_fwd_duty; $fell(fwd) |-> (!fwd) [*4] ##1 fwd; endproperty
   a_fwd_duty: assert property (p_fwd_duty) else $error("Clock duty wrong.");
endmodule
bind adc_output_stage adc_out_checker u_chk (.i_clk, .i_rst, .i_format_select_pin,
   .i_data_format_bit, .i_use_serial_cfg, .o_data, .o_data_valid, .o_overrange_flag,
   .o_ddr_pair, .o_forwarded_clock_pos, .o_forwarded_clock_cmos);
`default_nettype wire

// >>> capture_model.sv
`timescale 1ns/1ps
`default_nettype none
module capture_model
   import adc_out_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_cmos,
   input wire logic [CODE_W-1:0] i_data,
   input wire logic i_valid,
   input wire logic i_flag,
   input wire logic [DDR_PAIRS-1:0] i_pair,
   input wire logic i_fwd_pos,
   input wire logic i_fwd_cmos,
   output logic o_stb,
   output logic [CODE_W-1:0] o_data,
   output logic [CODE_W-1:0] o_ddr_word,
   output logic o_valid,
   output logic o_flag
);
   // ---------------------------------------------------------------
   // Capture on the forwarded clock
   // ---------------------------------------------------------------
   logic fwd_r;
   logic [DDR_PAIRS-1:0] even_r;
   wire logic fwd = i_cmos ? i_fwd_cmos : i_fwd_pos;
   // Edges are seen one cycle late, so the pair then still holds that edge's half.
   always_ff @(posedge i_clk) begin
      fwd_r <= fwd;
      o_stb <= fwd && !fwd_r;
      if (fwd && !fwd_r) begin
         o_data <= i_data;
         o_valid <= i_valid;
         o_flag <= i_flag;
         for (int k = 0; k < DDR_PAIRS; k++) begin
            o_ddr_word[2*k] <= even_r[k];
            o_ddr_word[2*k+1] <= i_pair[k];
         end
      end
      if (!fwd && fwd_r) even_r <= i_pair;
   end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
   $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
module testbench;
   import adc_out_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus, model and scoreboard
   // ---------------------------------------------------------------
   logic i_clk = 0, i_rst = 1, i_sample_clk = 0, i_format_select_pin = 0;
   logic i_data_format_bit = 0, i_use_serial_cfg = 0, i_output_interface_bit = 0;
   logic i_rate_below_80 = 0, i_smp_over_pos = 0, i_smp_over_neg = 0, i_smp_valid = 0;
   logic [CODE_W-1:0] i_smp_code = 14'h0000;
   wire logic o_smp_ready, o_data_valid, o_overrange_flag, o_forwarded_clock_pos;
   wire logic o_forwarded_clock_cmos, cstb, cvld, cflg;
   wire logic [CODE_W-1:0] o_data, cdat, cddr;
   wire logic [DDR_PAIRS-1:0] o_ddr_pair;
   int failures = 0, checks_done = 0, seed = 32'h2f4aab81, cyc = 0, lat, cap_n, j;
   logic tc, run = 0;
   logic [WORD_W-1:0] q[$];
   adc_output_stage dut (.i_clk, .i_rst, .i_sample_clk, .i_format_select_pin,
      .i_data_format_bit, .i_use_serial_cfg, .i_output_interface_bit, .i_rate_below_80,
      .i_smp_code, .i_smp_over_pos, .i_smp_over_neg, .i_smp_valid, .o_smp_ready, .o_data,
      .o_data_valid, .o_overrange_flag, .o_ddr_pair, .o_forwarded_clock_pos,
      .o_forwarded_clock_cmos);
   capture_model cap (.i_clk, .i_cmos(i_output_interface_bit), .i_data(o_data),
      .i_valid(o_data_valid), .i_flag(o_overrange_flag), .i_pair(o_ddr_pair),
      .i_fwd_pos(o_forwarded_clock_pos), .i_fwd_cmos(o_forwarded_clock_cmos), .o_stb(cstb),
      .o_data(cdat), .o_ddr_word(cddr), .o_valid(cvld), .o_flag(cflg));
   // Positive overdrive wins; the format flips only the top bit.
   function automatic logic [CODE_W-1:0] exp_code(logic [WORD_W-1:0] w, logic f);
      return (w[POS_BIT] ? 14'h3fff : w[NEG_BIT] ? 14'h0000 : w[CODE_W-1:0]) ^ {f, 13'h0};
   endfunction
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Clock and a ceiling well above the eight configurations' run time.
   initial forever #20 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         test_done();
      end
   end
   // Capture n carries the word that entered at sampling rise n minus the latency.
   always @(posedge i_clk) begin
      if (run && cstb === 1'b1) begin
         cap_n++;
         j = cap_n - 1 - lat;
         if (j >= 0 && j < q.size()) begin
            `CHK(cvld, 1'b1)
            `CHK(cflg, q[j][POS_BIT] | q[j][NEG_BIT])
            `CHK(cdat, exp_code(q[j], tc))
            if (!i_output_interface_bit) `CHK(cddr, exp_code(q[j], tc))
         end else begin
            `CHK(cvld, 1'b0)
            `CHK(cflg, 1'b0)
            `CHK(cdat, exp_code({WORD_W{1'b0}}, tc))
         end
      end
   end
   // Each pass: mode, rate and format source under reset, fill the buffer, then sample.
   initial begin
      int k;
      for (int m = 0; m < 8; m++) begin
         @(posedge i_clk);
         i_rst <= 1'b1;
         i_output_interface_bit <= m[0];
         i_rate_below_80 <= m[1];
         i_use_serial_cfg <= m[1];
         i_data_format_bit <= m[2] ^ !m[1];
         i_format_select_pin <= m[2] ^ m[1];
         tc = m[2];
         lat = (m[0] && m[1]) ? LAT_SLOW_CMOS : LAT_STD;
         repeat (20) @(posedge i_clk);
         i_rst <= 1'b0;
         q.delete();
         i_smp_code <= 14'($random(seed));
         i_smp_over_pos <= 1'b0;
         i_smp_over_neg <= 1'b0;
         i_smp_valid <= 1'b1;
         repeat (12) begin
            @(posedge i_clk);
            if (o_smp_ready === 1'b1) begin
               q.push_back({i_smp_over_neg, i_smp_over_pos, i_smp_code});
               k = q.size();
               i_smp_code <= 14'($random(seed));
               i_smp_over_pos <= k[0];
               i_smp_over_neg <= k[1];
            end
         end
         i_smp_valid <= 1'b0;
         `CHK(q.size(), FIFO_DEPTH)
         `CHK(o_smp_ready, 1'b0)
         cap_n = 0;
         run = 1'b1;
         repeat (lat + 10) begin
            i_sample_clk <= 1'b1;
            repeat (4) @(posedge i_clk);
            i_sample_clk <= 1'b0;
            repeat (4) @(posedge i_clk);
         end
         repeat (8) @(posedge i_clk);
         run = 1'b0;
         `CHK(cap_n, lat + 10)
         `CHK(o_smp_ready, 1'b1)
         $display("Configuration %0d finished", m);
      end
      test_done();
   end
endmodule
`default_nettype wire
